// File: logic/ecu_ext_ctrl.sv
// Extended device control upper fields with APB access and control outputs
//
// Notes on behaviour
// [RQ1] Bit 19 enables dynamic DMA/MAC gating, NVM default
// [RQ2] Fuse forces gating output zero, reads stored
// [RQ3] Bit 20 resets one, allows PHY low power
// [RQ4] Gigabit always clocks DMA from PLL/2
// [RQ5] Non-gigabit, select zero picks oscillator clock
// [RQ6] Test mode: select and keep-on give PLL/2
// [RQ7] Bit 26 clear: PLL runs only when needed
// [RQ8] Bit 26 set keeps PLL always running
// [RQ9] Bit 27: cause access copies automask to clear
// [RQ10] Driver sets/clears bit 28; soft reset clears
// [RQ11] Driver-present bit goes to manageability controller
// [RQ12] Bit 29: mask-set write restarts delay timers
// [RQ13] Bit 29 clear: no timer restart on unmask
// [RQ14] Reserved bits read zero, writes ignored
// [RQ15] Reload command reloads NVM defaults into fields
// [RQ16] Software saves/restores registers around reload
// [RQ17] Reloaded base address waits for remap
// [RQ18] Bypass applies forced speed immediately
// [RQ19] Bit 15 bypasses speed detection entirely
// [RQ20] Speed 00=10, 01=100, 1x=1000 Mb/s
// [RQ21] Reset values first, then NVM load overwrites
`timescale 1ns/1ps
module ecu_ext_ctrl #(
	parameter int ADDR_W = 16,
	parameter int BAR_W = 32
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	input wire logic i_soft_rst,
	input wire logic i_gate_fuse_disable,
	input wire logic i_nvm_load_done,
	input wire logic [15:0] i_nvm_word13,
	input wire logic [BAR_W-1:0] i_nvm_bar_value,
	input wire logic i_remap_strobe,
	input wire logic i_dma_quarter_clk_cap,
	input wire logic i_dma_off_state,
	input wire logic i_power_d3,
	input wire logic i_power_dr,
	input wire logic i_wol_enabled,
	input wire logic i_link_pll_needed,
	input wire logic [1:0] i_detected_speed,
	input wire logic i_clk_switch_done,
	input wire logic i_int_cause_access,
	input wire logic i_int_mask_set_write,
	input wire logic [31:0] i_automask_value,
	output logic o_dynamic_gate_en,
	output logic o_phy_lowpower_ok,
	output logic o_dma_clk_from_pll,
	output logic o_link_pll_run,
	output logic o_driver_present,
	output logic o_imc_copy_we,
	output logic [31:0] o_imc_copy_data,
	output logic o_int_timer_restart,
	output logic o_nvm_reload_req,
	output logic [1:0] o_mac_speed,
	output logic [BAR_W-1:0] o_bar_config
);
	import ecu_pkg::*;

	typedef struct packed {
		logic bypass;
		logic dyn_gate;
		logic phy_lp;
		logic dma_sel;
		logic pll_keep;
		logic automask;
		logic driver;
		logic timer_rst;
		logic force_en;
		logic [1:0] forced_speed;
		logic [1:0] speed;
		ecu_nvm_st_t nvm_st;
		logic [BAR_W-1:0] bar_pending;
		logic [BAR_W-1:0] bar_active;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic gate_out;
		logic phy_lp_ok;
		logic dma_pll;
		logic pll_run;
		logic imc_we;
		logic [31:0] imc_data;
		logic timer_restart;
		logic nvm_req;
	} ecu_state_t;

	ecu_state_t st;
	ecu_state_t next_st;

	logic setup_phase;
	logic wr_done;
	logic addr_ok;
	logic [31:0] ext_rd;
	logic [31:0] spd_rd;
	logic [31:0] stat_rd;
	logic [31:0] wmask;
	logic [31:0] wdata;
	logic [1:0] next_speed;
	logic [31:0] rd_sel;
	logic nvm_busy;
	logic reload_accept;
	logic low_power_state;
	logic gigabit_mode;
	logic gate_allowed;
	logic automask_copy;
	logic unmask_restart;

	assign setup_phase = i_psel && !i_penable && !st.pready;
	assign wr_done = i_psel && i_penable && st.pready && i_pwrite;
	assign wmask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
	assign wdata = i_pwdata & wmask;

	assign nvm_busy = (st.nvm_st == ECU_NVM_WAIT);
	// Reload requests are dropped while an NVM read is still in flight
	assign reload_accept = wdata[ECU_CMD_RELOAD_BIT] && !nvm_busy;
	// Power states in which the PHY may drop to low power
	assign low_power_state = i_dma_off_state || i_power_d3 || i_power_dr; // see [RQ3]
	// Both codes with the upper bit set mean gigabit
	assign gigabit_mode = st.speed[1]; // see [RQ20]
	// The fuse hides the bit from the gating logic only, never from reads
	assign gate_allowed = !i_gate_fuse_disable; // see [RQ2]
	assign automask_copy = i_int_cause_access && st.automask; // see [RQ9]
	assign unmask_restart = i_int_mask_set_write && st.timer_rst; // see [RQ12] see [RQ13]

	// Read views of each register
	always_comb begin
		ext_rd = 32'h0000_0000; // see [RQ14]
		ext_rd[ECU_BYPASS_BIT] = st.bypass;
		ext_rd[ECU_DYN_GATE_BIT] = st.dyn_gate; // see [RQ2]
		ext_rd[ECU_PHY_LP_BIT] = st.phy_lp;
		ext_rd[ECU_DMA_SEL_BIT] = st.dma_sel;
		ext_rd[ECU_PLL_KEEP_BIT] = st.pll_keep;
		ext_rd[ECU_AUTOMASK_BIT] = st.automask;
		ext_rd[ECU_DRIVER_BIT] = st.driver;
		ext_rd[ECU_TIMER_RST_BIT] = st.timer_rst;
		spd_rd = 32'h0000_0000;
		spd_rd[ECU_FORCED_SPEED_LSB +: 2] = st.forced_speed;
		spd_rd[ECU_FORCE_BIT] = st.force_en;
		stat_rd = 32'h0000_0000;
		stat_rd[ECU_ST_SPEED_LSB +: 2] = st.speed;
		stat_rd[ECU_ST_PLL_RUN_BIT] = st.pll_run;
		stat_rd[ECU_ST_DMA_PLL_BIT] = st.dma_pll;
		stat_rd[ECU_ST_PHY_LP_BIT] = st.phy_lp_ok;
		stat_rd[ECU_ST_GATE_BIT] = st.gate_out;
		stat_rd[ECU_ST_NVM_BUSY_BIT] = nvm_busy;
		stat_rd[ECU_ST_QUARTER_BIT] = i_dma_quarter_clk_cap;
		// Address decode and the word a read would return
		rd_sel = 32'h0000_0000;
		case (i_paddr[15:0])
			ECU_EXT_CTRL_ADDR: begin
				addr_ok = 1'b1;
				rd_sel = ext_rd;
			end
			ECU_SPEED_CTRL_ADDR: begin
				addr_ok = 1'b1;
				rd_sel = spd_rd;
			end
			ECU_STATUS_ADDR: begin
				addr_ok = 1'b1;
				rd_sel = stat_rd;
			end
			// Command bits are strobes and read back as zero
			ECU_COMMAND_ADDR: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// Speed actually applied to the MAC
	always_comb begin
		next_speed = st.speed;
		if (st.bypass) begin
			next_speed = st.forced_speed; // see [RQ18] see [RQ19]
		end else if (i_clk_switch_done) begin
			next_speed = st.force_en ? st.forced_speed : i_detected_speed;
		end
	end

	always_comb begin
		next_st = st;
		next_st.imc_we = 1'b0;
		next_st.timer_restart = 1'b0;
		next_st.nvm_req = 1'b0;

		// APB: one access cycle, answer prepared in the setup cycle
		next_st.pready = setup_phase;
		if (setup_phase) begin
			next_st.pslverr = !addr_ok;
			next_st.prdata = 32'h0000_0000;
			if (!i_pwrite) begin
				next_st.prdata = rd_sel;
			end
		end else if (st.pready) begin
			next_st.pslverr = 1'b0;
		end

		// Register writes take effect at the completing edge
		if (wr_done) begin
			case (i_paddr[15:0])
				ECU_EXT_CTRL_ADDR: begin
					if (i_pstrb[1]) begin
						next_st.bypass = wdata[ECU_BYPASS_BIT];
					end
					if (i_pstrb[2]) begin
						next_st.dyn_gate = wdata[ECU_DYN_GATE_BIT];
						next_st.phy_lp = wdata[ECU_PHY_LP_BIT];
					end
					if (i_pstrb[3]) begin
						next_st.dma_sel = wdata[ECU_DMA_SEL_BIT];
						next_st.pll_keep = wdata[ECU_PLL_KEEP_BIT]; // see [RQ8]
						next_st.automask = wdata[ECU_AUTOMASK_BIT];
						next_st.driver = wdata[ECU_DRIVER_BIT]; // see [RQ10]
						next_st.timer_rst = wdata[ECU_TIMER_RST_BIT];
					end
				end
				ECU_SPEED_CTRL_ADDR: begin
					if (i_pstrb[0]) begin
						next_st.forced_speed = wdata[ECU_FORCED_SPEED_LSB +: 2];
						next_st.force_en = wdata[ECU_FORCE_BIT];
					end
				end
				ECU_COMMAND_ADDR: begin
					if (reload_accept) begin
						next_st.nvm_req = 1'b1; // see [RQ15]
						next_st.nvm_st = ECU_NVM_WAIT;
					end
				end
				default: begin
				end
			endcase
		end

		// Soft reset restores reset values, driver flag included
		if (i_soft_rst) begin
			next_st.bypass = ECU_BYPASS_RST;
			next_st.dyn_gate = ECU_DYN_GATE_RST;
			next_st.phy_lp = ECU_PHY_LP_RST;
			next_st.dma_sel = ECU_DMA_SEL_RST;
			next_st.pll_keep = ECU_PLL_KEEP_RST;
			next_st.automask = ECU_AUTOMASK_RST;
			next_st.driver = ECU_DRIVER_RST; // see [RQ10]
			next_st.timer_rst = ECU_TIMER_RST_RST;
			next_st.force_en = ECU_FORCE_RST;
			next_st.forced_speed = ECU_FORCED_SPEED_RST;
		end

		// NVM load overwrites loaded fields; base address only staged
		case (st.nvm_st)
			ECU_NVM_IDLE: begin
			end
			ECU_NVM_WAIT: begin
				if (i_nvm_load_done) begin
					next_st.nvm_st = ECU_NVM_IDLE;
				end
			end
			default: next_st.nvm_st = ECU_NVM_IDLE;
		endcase
		if (i_nvm_load_done) begin
			next_st.dyn_gate = i_nvm_word13[ECU_NVM_DYN_GATE_BIT]; // see [RQ1] see [RQ21]
			next_st.phy_lp = i_nvm_word13[ECU_NVM_PHY_LP_BIT]; // see [RQ3] see [RQ21]
			next_st.bar_pending = i_nvm_bar_value; // see [RQ17]
		end
		if (i_remap_strobe) begin
			next_st.bar_active = st.bar_pending; // see [RQ17]
		end

		next_st.speed = next_speed;

		// Control outputs derived from the stored fields
		next_st.gate_out = st.dyn_gate && gate_allowed; // see [RQ1] see [RQ2]
		next_st.phy_lp_ok = st.phy_lp && !i_wol_enabled && low_power_state; // see [RQ3]
		// Gigabit (1x) forces PLL/2; otherwise the select bit decides
		next_st.dma_pll = gigabit_mode || st.dma_sel; // see [RQ4] see [RQ5] see [RQ6] see [RQ20]
		next_st.pll_run = st.pll_keep || i_link_pll_needed; // see [RQ7] see [RQ8]

		// Interrupt side effects
		if (automask_copy) begin
			next_st.imc_we = 1'b1; // see [RQ9]
			next_st.imc_data = i_automask_value;
		end
		next_st.timer_restart = unmask_restart; // see [RQ12] see [RQ13]
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st.bypass <= ECU_BYPASS_RST;
			st.dyn_gate <= ECU_DYN_GATE_RST; // see [RQ21]
			st.phy_lp <= ECU_PHY_LP_RST; // see [RQ3]
			st.dma_sel <= ECU_DMA_SEL_RST;
			st.pll_keep <= ECU_PLL_KEEP_RST;
			st.automask <= ECU_AUTOMASK_RST;
			st.driver <= ECU_DRIVER_RST;
			st.timer_rst <= ECU_TIMER_RST_RST;
			st.force_en <= ECU_FORCE_RST;
			st.forced_speed <= ECU_FORCED_SPEED_RST;
			st.speed <= ECU_SPEED_RST;
			st.nvm_st <= ECU_NVM_IDLE;
			st.bar_pending <= '0;
			st.bar_active <= '0;
			st.pready <= 1'b0;
			st.prdata <= 32'h0000_0000;
			st.pslverr <= 1'b0;
			st.gate_out <= 1'b0;
			st.phy_lp_ok <= 1'b0;
			st.dma_pll <= 1'b0;
			st.pll_run <= 1'b0;
			st.imc_we <= 1'b0;
			st.imc_data <= 32'h0000_0000;
			st.timer_restart <= 1'b0;
			st.nvm_req <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign o_pready = st.pready;
	assign o_prdata = st.prdata;
	assign o_pslverr = st.pslverr;
	assign o_dynamic_gate_en = st.gate_out;
	assign o_phy_lowpower_ok = st.phy_lp_ok;
	assign o_dma_clk_from_pll = st.dma_pll;
	assign o_link_pll_run = st.pll_run;
	assign o_driver_present = st.driver; // see [RQ11]
	assign o_imc_copy_we = st.imc_we;
	assign o_imc_copy_data = st.imc_data;
	assign o_int_timer_restart = st.timer_restart;
	assign o_nvm_reload_req = st.nvm_req;
	assign o_mac_speed = st.speed;
	assign o_bar_config = st.bar_active;
endmodule

// File: logic/ecu_pkg.sv
// Constants and types shared by the extended control upper-field block
package ecu_pkg;
	// Register byte addresses
	localparam logic [15:0] ECU_EXT_CTRL_ADDR = 16'h0018;
	localparam logic [15:0] ECU_SPEED_CTRL_ADDR = 16'h0100;
	localparam logic [15:0] ECU_STATUS_ADDR = 16'h0104;
	localparam logic [15:0] ECU_COMMAND_ADDR = 16'h0108;

	// Extended control field positions
	localparam int ECU_BYPASS_BIT = 15;
	localparam int ECU_DYN_GATE_BIT = 19;
	localparam int ECU_PHY_LP_BIT = 20;
	localparam int ECU_DMA_SEL_BIT = 25;
	localparam int ECU_PLL_KEEP_BIT = 26;
	localparam int ECU_AUTOMASK_BIT = 27;
	localparam int ECU_DRIVER_BIT = 28;
	localparam int ECU_TIMER_RST_BIT = 29;

	// Extended control reset values
	localparam logic ECU_BYPASS_RST = 1'b0;
	localparam logic ECU_DYN_GATE_RST = 1'b0;
	localparam logic ECU_PHY_LP_RST = 1'b1;
	localparam logic ECU_DMA_SEL_RST = 1'b0;
	localparam logic ECU_PLL_KEEP_RST = 1'b0;
	localparam logic ECU_AUTOMASK_RST = 1'b0;
	localparam logic ECU_DRIVER_RST = 1'b0;
	localparam logic ECU_TIMER_RST_RST = 1'b0;

	// Speed control fields
	localparam int ECU_FORCED_SPEED_LSB = 0;
	localparam int ECU_FORCE_BIT = 2;
	localparam logic [1:0] ECU_FORCED_SPEED_RST = 2'h0;
	localparam logic ECU_FORCE_RST = 1'b0;

	// Status fields
	localparam int ECU_ST_SPEED_LSB = 0;
	localparam int ECU_ST_PLL_RUN_BIT = 2;
	localparam int ECU_ST_DMA_PLL_BIT = 3;
	localparam int ECU_ST_PHY_LP_BIT = 4;
	localparam int ECU_ST_GATE_BIT = 5;
	localparam int ECU_ST_NVM_BUSY_BIT = 6;
	localparam int ECU_ST_QUARTER_BIT = 7;

	// Command fields
	localparam int ECU_CMD_RELOAD_BIT = 0;

	// Positions of the loaded defaults within NVM word 13h
	localparam int ECU_NVM_DYN_GATE_BIT = 0;
	localparam int ECU_NVM_PHY_LP_BIT = 1;

	// Speed encodings
	localparam logic [1:0] ECU_SPEED_10 = 2'h0;
	localparam logic [1:0] ECU_SPEED_100 = 2'h1;
	localparam logic [1:0] ECU_SPEED_RST = 2'h0;

	typedef enum logic [0:0] {
		ECU_NVM_IDLE,
		ECU_NVM_WAIT
	} ecu_nvm_st_t;
endpackage

// File: test/ecu_ext_chk.sv
// Port-level checks for the extended control block
`timescale 1ns/1ps
module ecu_ext_chk (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_gate_fuse_disable,
	input wire logic o_dynamic_gate_en,
	input wire logic i_int_cause_access,
	input wire logic o_imc_copy_we,
	input wire logic i_int_mask_set_write,
	input wire logic o_int_timer_restart,
	input wire logic i_soft_rst,
	input wire logic o_driver_present,
	input wire logic i_link_pll_needed,
	input wire logic o_link_pll_run
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_setup;
		i_psel && !i_penable && !o_pready;
	endsequence
	sequence s_answer;
		o_pready ##1 !o_pready;
	endsequence
	a_setup_gets_ready: assert property (s_setup |=> s_answer)
		else $error("ready not one cycle after setup");
	a_err_with_ready: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	a_fuse_blocks_gate: assert property ($past(i_gate_fuse_disable) |-> !o_dynamic_gate_en)
		else $error("gate enable with fuse set");
	a_copy_has_cause: assert property (o_imc_copy_we |-> $past(i_int_cause_access))
		else $error("mask copy without cause access");
	a_copy_one_cycle: assert property (o_imc_copy_we |=> !o_imc_copy_we || $past(i_int_cause_access))
		else $error("mask copy too long");
	a_restart_has_write: assert property (o_int_timer_restart |-> $past(i_int_mask_set_write))
		else $error("timer restart without mask set write");
	a_soft_clears_drv: assert property (i_soft_rst |-> ##2 !o_driver_present)
		else $error("driver flag survives soft reset");
	a_pll_when_needed: assert property ($past(i_link_pll_needed) && $past(i_rst_n) |-> o_link_pll_run)
		else $error("link pll stopped while needed");
endmodule

bind ecu_ext_ctrl ecu_ext_chk u_chk (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .i_gate_fuse_disable(i_gate_fuse_disable),
	.o_dynamic_gate_en(o_dynamic_gate_en), .i_int_cause_access(i_int_cause_access),
	.o_imc_copy_we(o_imc_copy_we), .i_int_mask_set_write(i_int_mask_set_write),
	.o_int_timer_restart(o_int_timer_restart), .i_soft_rst(i_soft_rst),
	.o_driver_present(o_driver_present), .i_link_pll_needed(i_link_pll_needed),
	.o_link_pll_run(o_link_pll_run));

// File: test/ecu_tb.sv
// Self-checking bench for the extended control block
`timescale 1ns/1ps
module testbench;
	import ecu_pkg::*;
	logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_fuse, i_doff, i_wol, i_need, i_d3, i_dr;
	logic [15:0] i_paddr;
	logic [31:0] i_pwdata, rd, sv, cw_data;
	logic [5:0] pv;
	logic o_pready, o_pslverr, o_gate, o_lp, o_dma, o_run, o_drv, o_cw, o_tr, o_rl, er;
	logic [31:0] o_prdata, o_cd, o_bar;
	logic [1:0] o_spd;
	int num_errors, n_tests, n_copy, n_rst, n_rel;
	logic [31:0] tw[5] = '{32'hFFFF_FFFF, 32'h0000_0000, 32'h0200_0000, 32'h0400_0000, 32'hC1E0_0000};
	logic [31:0] tr[5] = '{32'h3E18_8000, 32'h0000_0000, 32'h0200_0000, 32'h0400_0000, 32'h0000_0000};
	logic [1:0] te[5] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h0};
	ecu_ext_ctrl dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.i_pstrb(4'hF), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
		.i_soft_rst(pv[0]), .i_gate_fuse_disable(i_fuse), .i_nvm_load_done(pv[1]),
		.i_nvm_word13(16'h0001), .i_nvm_bar_value(32'h1234_0000), .i_remap_strobe(pv[2]),
		.i_dma_quarter_clk_cap(i_wol), .i_dma_off_state(i_doff), .i_power_d3(i_d3),
		.i_power_dr(i_dr), .i_wol_enabled(i_wol), .i_link_pll_needed(i_need),
		.i_detected_speed(2'h2), .i_clk_switch_done(pv[5]), .i_int_cause_access(pv[3]),
		.i_int_mask_set_write(pv[4]), .i_automask_value(32'hA5A5_0F0F),
		.o_dynamic_gate_en(o_gate), .o_phy_lowpower_ok(o_lp), .o_dma_clk_from_pll(o_dma),
		.o_link_pll_run(o_run), .o_driver_present(o_drv), .o_imc_copy_we(o_cw),
		.o_imc_copy_data(o_cd), .o_int_timer_restart(o_tr), .o_nvm_reload_req(o_rl),
		.o_mac_speed(o_spd), .o_bar_config(o_bar));
	initial begin
		i_clk = 0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (o_cw === 1'b1) begin
			n_copy++;
			cw_data = o_cd;
		end
		if (o_tr === 1'b1) n_rst++;
		if (o_rl === 1'b1) n_rel++;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cb(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int k;
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		tick(1);
		i_penable <= 1'b1;
		k = 0;
		do begin
			tick(1);
			k++;
		end while (o_pready !== 1'b1 && k < 20);
		if (k >= 20) num_errors++;
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		tick(1);
	endtask
	task automatic pulse(input int b);
		pv[b] <= 1'b1;
		tick(1);
		pv <= '0;
		tick(3);
	endtask
	task automatic summarize();
		$display("errors %0d compares %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		summarize();
	end
	initial begin
		{i_rst_n, i_psel, i_penable, i_pwrite, i_fuse, i_doff, i_wol, i_need, i_d3, i_dr} = '0;
		{i_paddr, i_pwdata, pv} = '0;
		tick(6);
		i_rst_n <= 1'b1;
		apb(0, ECU_EXT_CTRL_ADDR, 0);
		chk(rd, 32'h0010_0000);
		apb(0, 16'h0200, 0);
		chk(rd, 0);
		cb(er, 1);
		for (int i = 0; i < 5; i++) begin
			apb(1, ECU_EXT_CTRL_ADDR, tw[i]);
			apb(0, ECU_EXT_CTRL_ADDR, 0);
			chk(rd, tr[i]);
			chk({30'h0, o_run, o_dma}, {30'h0, te[i]});
		end
		i_need <= 1'b1;
		tick(3);
		cb(o_run, 1);
		i_need <= 1'b0;
		apb(1, ECU_EXT_CTRL_ADDR, 32'h0008_0000);
		tick(1);
		cb(o_gate, 1);
		i_fuse <= 1'b1;
		tick(3);
		cb(o_gate, 0);
		apb(0, ECU_EXT_CTRL_ADDR, 0);
		chk(rd, 32'h0008_0000);
		apb(1, ECU_EXT_CTRL_ADDR, 32'h0010_0000);
		i_doff <= 1'b1;
		tick(3);
		cb(o_lp, 1);
		i_wol <= 1'b1;
		tick(3);
		cb(o_lp, 0);
		{i_wol, i_doff, i_d3} <= 3'h1;
		tick(3);
		cb(o_lp, 1);
		{i_d3, i_dr} <= 2'h1;
		tick(3);
		cb(o_lp, 1);
		i_dr <= 1'b0;
		tick(3);
		cb(o_lp, 0);
		apb(1, ECU_SPEED_CTRL_ADDR, 32'h0000_0002);
		apb(1, ECU_EXT_CTRL_ADDR, 32'h0000_8000);
		tick(2);
		chk({30'h0, o_spd}, 2);
		cb(o_dma, 1);
		apb(1, ECU_SPEED_CTRL_ADDR, 32'h0000_0001);
		tick(2);
		chk({30'h0, o_spd}, 1);
		cb(o_dma, 0);
		apb(1, ECU_EXT_CTRL_ADDR, 32'h0000_0000);
		apb(1, ECU_SPEED_CTRL_ADDR, 32'h0000_0004);
		tick(2);
		chk({30'h0, o_spd}, 1);
		pulse(5);
		chk({30'h0, o_spd}, 0);
		apb(1, ECU_SPEED_CTRL_ADDR, 32'h0000_0000);
		pulse(5);
		chk({30'h0, o_spd}, 2);
		apb(1, ECU_EXT_CTRL_ADDR, 32'h0800_0000);
		pulse(3);
		chk(n_copy, 1);
		chk(cw_data, 32'hA5A5_0F0F);
		apb(1, ECU_EXT_CTRL_ADDR, 32'h2000_0000);
		pulse(3);
		chk(n_copy, 1);
		pulse(4);
		chk(n_rst, 1);
		apb(1, ECU_EXT_CTRL_ADDR, 32'h1000_0000);
		pulse(4);
		chk(n_rst, 1);
		cb(o_drv, 1);
		pulse(0);
		cb(o_drv, 0);
		apb(0, ECU_EXT_CTRL_ADDR, 0);
		chk(rd, 32'h0010_0000);
		sv = rd;
		apb(1, ECU_COMMAND_ADDR, 1);
		tick(2);
		chk(n_rel, 1);
		pulse(1);
		apb(0, ECU_EXT_CTRL_ADDR, 0);
		chk(rd, 32'h0008_0000);
		chk(o_bar, 0);
		pulse(2);
		chk(o_bar, 32'h1234_0000);
		apb(1, ECU_EXT_CTRL_ADDR, sv);
		apb(0, ECU_EXT_CTRL_ADDR, 0);
		chk(rd, 32'h0010_0000);
		summarize();
	end
endmodule
